/* hdl/i2c_master_consts.svh */
`ifndef I2C_MASTER_CONSTS_SVH
`define I2C_MASTER_CONSTS_SVH

// Register byte offsets
`define OFS_BUS_CONTROL 12'h000
`define OFS_PORT_STATUS 12'h004
`define OFS_RATE_RELOAD 12'h008
`define OFS_TRANSFER_BUF 12'h00c

// Bus control field positions
`define BIT_START_REQ 0
`define BIT_RESTART_REQ 1
`define BIT_RECEIVE_REQ 3
`define BIT_ACK_SEQ_REQ 4
`define BIT_ACK_VALUE 5
`define BIT_ACK_STATUS 6
`define REQ_MASK 5'h1b

// Reset values
`define RST_RELOAD 7'h09
`define RST_REQ 5'h00

// Bit counter value at the last data bit of a byte and at the acknowledge bit
`define LAST_DATA_BIT 4'h7
`define ACK_BIT 4'h8

`endif

/* hdl/i2c_master_pkg.sv */
package i2c_master_pkg;

	// Sticky status flags, high bit first: buffer full sits in bit 0
	typedef struct packed {
		logic collisionIrqFlag;
		logic portIrqFlag;
		logic receiveOverflowFlag;
		logic startDetected;
		logic writeCollisionFlag;
		logic bufferFullFlag;
	} port_status_t;

	typedef enum logic [3:0] {
		IDLE = 4'h0,
		ST_WAIT = 4'h1,
		ST_HOLD = 4'h3,
		RS_PULL = 4'h2,
		RS_SDA = 4'h6,
		RS_RISE = 4'h7,
		RS_HIGH = 4'h5,
		RS_HOLD = 4'h4,
		TX_LOW = 4'hc,
		TX_HIGH = 4'hd,
		RX_LOW = 4'hf,
		RX_HIGH = 4'he,
		ACK_LOW = 4'ha,
		ACK_HIGH = 4'hb
	} seq_state_t;

endpackage : i2c_master_pkg

/* hdl/i2c_master_sequencer.sv */
// Local design decisions: the APB register port and the address map.
`timescale 1ns/100ps
`include "i2c_master_consts.svh"
module i2c_master_sequencer
	import i2c_master_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe
);

	seq_state_t state;
	port_status_t status;
	logic [4:0] reqs;
	logic ackValue, ackStatus;
	logic [6:0] reload, brgCnt;
	logic brgRun, brgLoad, brgShort;
	logic [1:0] phase;
	logic [7:0] shiftReg, transferBuffer;
	logic [3:0] bitCnt;
	logic sclMeta, sclS, sdaMeta, sdaS, sdaPrev;

	// Bus access decode
	wire access = psel && penable;
	wire hitCtrl = paddr == `OFS_BUS_CONTROL;
	wire hitStat = paddr == `OFS_PORT_STATUS;
	wire hitRel = paddr == `OFS_RATE_RELOAD;
	wire hitBuf = paddr == `OFS_TRANSFER_BUF;
	wire mapped = hitCtrl || hitStat || hitRel || hitBuf;
	wire ctrlWr = access && pwrite && hitCtrl;
	wire statWr = access && pwrite && hitStat;
	wire relWr = access && pwrite && hitRel;
	wire bufWr = access && pwrite && hitBuf;
	wire bufRd = access && !pwrite && hitBuf;
	assign pready = 1'b1;
	assign pslverr = access && !mapped;

	// Nothing may be queued: new commands only from a quiet idle
	wire quiet = state == IDLE && reqs == `RST_REQ;
	wire ctrlAccept = ctrlWr && quiet;
	wire bufAccept = bufWr && quiet;

	// Generator ticks on two of four phases; a stretched SCL freezes it
	wire tick = phase[0];
	wire stretch = !sclOe && !sclS;
	wire brgExp = brgRun && tick && !stretch && brgCnt == 7'h00;

	// Line checks that abort a start or restart
	wire collide = (state == IDLE && reqs[`BIT_START_REQ] && !(sclS && sdaS))
		|| (state == ST_WAIT && (!sclS || (brgExp && !sdaS)))
		|| (state == RS_SDA && brgExp && !sdaS)
		|| (state == RS_RISE && sclS && !sdaS)
		|| (state == RS_HIGH && (!sclS || !sdaS));

	// Sequence events feeding the sticky flags
	wire startEv = sclS && sdaPrev && !sdaS;
	wire txNinth = state == TX_HIGH && brgExp && bitCnt == `ACK_BIT;
	wire bfClrEv = state == TX_HIGH && brgExp && bitCnt == `LAST_DATA_BIT;
	wire rxDone = state == RX_HIGH && brgExp && bitCnt == `LAST_DATA_BIT;
	wire irqEv = ((state == ST_HOLD || state == RS_HOLD || state == ACK_HIGH) && brgExp)
		|| txNinth || rxDone;
	wire txActive = state == TX_LOW || state == TX_HIGH;
	wire bfClrRd = bufRd && !txActive;
	wire [7:0] rxByte = {shiftReg[6:0], sdaS};

	// Open drain: only ever pull low
	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;

	// Two-stage synchronisers, plus an SDA history stage for start detection
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			{sclMeta, sclS, sdaMeta, sdaS, sdaPrev} <= 5'h1f;
		end else begin
			{sclMeta, sclS} <= {sclIn, sclMeta};
			{sdaMeta, sdaS, sdaPrev} <= {sdaIn, sdaMeta, sdaS};
		end
	end

	// Baud generator: counts to zero, then stops until the next load
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			phase <= 2'h0;
			brgCnt <= 7'h00;
			brgRun <= 1'b0;
		end else begin
			phase <= phase + 2'h1;
			if (brgLoad) begin
				brgCnt <= brgShort ? {1'b0, reload[5:0]} : reload;
				brgRun <= 1'b1;
			end else if (brgExp) begin
				brgRun <= 1'b0;
			end else if (brgRun && tick && !stretch) begin
				brgCnt <= brgCnt - 7'h01;
			end
		end
	end

	// Rate reload register
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			reload <= `RST_RELOAD;
		end else if (relWr) begin
			reload <= pwdata[6:0];
		end
	end

	// Transfer buffer: refused writes leave it untouched
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			transferBuffer <= 8'h00;
		end else if (bufAccept) begin
			transferBuffer <= pwdata[7:0];
		end else if (rxDone) begin
			transferBuffer <= rxByte;
		end
	end

	// Sticky flags: write one to clear; a same-cycle event wins over the clear
	wire [5:0] setMask = {collide, irqEv, rxDone && status.bufferFullFlag, startEv,
		bufWr && !bufAccept, bufAccept || rxDone};
	wire [5:0] clrMask = (statWr ? pwdata[5:0] : 6'h00) | {5'h00, bfClrEv || bfClrRd || collide};
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			status <= '0;
		end else begin
			status <= (status & ~clrMask) | setMask;
		end
	end

	// Sequencer; the generator load is a registered one-cycle request
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= IDLE;
			reqs <= `RST_REQ;
			ackValue <= 1'b0;
			ackStatus <= 1'b0;
			sclOe <= 1'b0;
			sdaOe <= 1'b0;
			shiftReg <= 8'h00;
			bitCnt <= 4'h0;
			brgLoad <= 1'b0;
			brgShort <= 1'b0;
		end else begin
			brgLoad <= 1'b0;
			brgShort <= 1'b0;
			if (ctrlWr) begin
				ackValue <= pwdata[`BIT_ACK_VALUE];
			end
			if (ctrlAccept) begin
				reqs <= pwdata[4:0] & `REQ_MASK;
			end
			if (collide) begin
				state <= IDLE;
				reqs <= `RST_REQ;
				sclOe <= 1'b0;
				sdaOe <= 1'b0;
			end else if (bufAccept) begin
				shiftReg <= pwdata[7:0];
				bitCnt <= 4'h0;
				sclOe <= 1'b1;
				brgLoad <= 1'b1;
				state <= TX_LOW;
			end else begin
				if (state == TX_LOW && brgLoad) sdaOe <= bitCnt == `ACK_BIT ? 1'b0 : ~shiftReg[7];
				unique case (state)
					IDLE: begin
						if (reqs[`BIT_START_REQ]) begin
							brgLoad <= 1'b1;
							state <= ST_WAIT;
						end else if (reqs[`BIT_RESTART_REQ]) begin
							sclOe <= 1'b1;
							state <= RS_PULL;
						end else if (reqs[`BIT_RECEIVE_REQ]) begin
							sclOe <= 1'b1;
							sdaOe <= 1'b0;
							bitCnt <= 4'h0;
							brgLoad <= 1'b1;
							state <= RX_LOW;
						end else if (reqs[`BIT_ACK_SEQ_REQ]) begin
							sclOe <= 1'b1;
							sdaOe <= ~ackValue;
							brgLoad <= 1'b1;
							state <= ACK_LOW;
						end
					end
					ST_WAIT: if (brgExp) begin
						sdaOe <= 1'b1;
						brgLoad <= 1'b1;
						state <= ST_HOLD;
					end
					ST_HOLD: if (brgExp) begin
						reqs[`BIT_START_REQ] <= 1'b0;
						state <= IDLE;
					end
					RS_PULL: if (!sclS) begin
						sdaOe <= 1'b0;
						brgLoad <= 1'b1;
						brgShort <= 1'b1;
						state <= RS_SDA;
					end
					RS_SDA: if (brgExp) begin
						sclOe <= 1'b0;
						state <= RS_RISE;
					end
					RS_RISE: if (sclS) begin
						brgLoad <= 1'b1;
						state <= RS_HIGH;
					end
					RS_HIGH: if (brgExp) begin
						sdaOe <= 1'b1;
						brgLoad <= 1'b1;
						state <= RS_HOLD;
					end
					RS_HOLD: if (brgExp) begin
						reqs[`BIT_RESTART_REQ] <= 1'b0;
						state <= IDLE;
					end
					TX_LOW, RX_LOW, ACK_LOW: if (brgExp) begin
						sclOe <= 1'b0;
						brgLoad <= 1'b1;
						state <= state == TX_LOW ? TX_HIGH : (state == RX_LOW ? RX_HIGH : ACK_HIGH);
					end
					TX_HIGH: if (brgExp) begin
						sclOe <= 1'b1;
						if (bitCnt == `ACK_BIT) begin
							ackStatus <= sdaS;
							state <= IDLE;
						end else begin
							bitCnt <= bitCnt + 4'h1;
							shiftReg <= {shiftReg[6:0], 1'b0};
							brgLoad <= 1'b1;
							state <= TX_LOW;
						end
					end
					RX_HIGH: if (brgExp) begin
						sclOe <= 1'b1;
						shiftReg <= rxByte;
						if (bitCnt == `LAST_DATA_BIT) begin
							reqs[`BIT_RECEIVE_REQ] <= 1'b0;
							state <= IDLE;
						end else begin
							bitCnt <= bitCnt + 4'h1;
							brgLoad <= 1'b1;
							state <= RX_LOW;
						end
					end
					ACK_HIGH: if (brgExp) begin
						sclOe <= 1'b1;
						reqs[`BIT_ACK_SEQ_REQ] <= 1'b0;
						state <= IDLE;
					end
					default: state <= IDLE;
				endcase
			end
		end
	end

	// Read data is registered in the setup phase so it is stable in the access phase
	wire [31:0] ctrlView = {25'h0, ackStatus, ackValue, reqs};
	wire [31:0] readMux = hitCtrl ? ctrlView : hitStat ? {26'h0, status} :
		hitRel ? {25'h0, reload} : hitBuf ? {24'h0, transferBuffer} : 32'h0;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= 32'h0;
		end else if (psel && !penable) begin
			prdata <= readMux;
		end
	end

	property p_startLoad;
		@(posedge core_clk) disable iff (!reset_n)
		state == IDLE && reqs[`BIT_START_REQ] && sclS && sdaS |=> state == ST_WAIT ##1 brgRun;
	endproperty
	a_startLoad: assert property (p_startLoad) else $error("start did not load generator");

	property p_startEdge;
		@(posedge core_clk) disable iff (!reset_n)
		state == ST_WAIT && brgExp && !collide |=> sdaOe && state == ST_HOLD;
	endproperty
	a_startEdge: assert property (p_startEdge) else $error("start edge not driven");

	property p_startDone;
		@(posedge core_clk) disable iff (!reset_n)
		state == ST_HOLD && brgExp |=> !reqs[`BIT_START_REQ] && sdaOe && !brgRun;
	endproperty
	a_startDone: assert property (p_startDone) else $error("start did not complete");

	property p_startCollide;
		@(posedge core_clk) disable iff (!reset_n)
		state == IDLE && reqs[`BIT_START_REQ] && !(sclS && sdaS) |=> status.collisionIrqFlag && state == IDLE && !sdaOe;
	endproperty
	a_startCollide: assert property (p_startCollide) else $error("collision not flagged");

	property p_writeRefused;
		@(posedge core_clk) disable iff (!reset_n)
		bufWr && !quiet && !rxDone |=> status.writeCollisionFlag && transferBuffer == $past(transferBuffer);
	endproperty
	a_writeRefused: assert property (p_writeRefused) else $error("refused write changed buffer");

	property p_txStart;
		@(posedge core_clk) disable iff (!reset_n)
		bufAccept |=> status.bufferFullFlag && sclOe ##1 brgRun;
	endproperty
	a_txStart: assert property (p_txStart) else $error("write did not start shifting");

	property p_ackSample;
		@(posedge core_clk) disable iff (!reset_n)
		txNinth |=> ackStatus == $past(sdaS) && status.portIrqFlag && sclOe;
	endproperty
	a_ackSample: assert property (p_ackSample) else $error("acknowledge not sampled");

	property p_brgCount;
		@(posedge core_clk) disable iff (!reset_n)
		brgRun && !brgLoad && tick && !stretch && brgCnt != 7'h00 |=> brgCnt == $past(brgCnt) - 7'h01;
	endproperty
	a_brgCount: assert property (p_brgCount) else $error("generator did not decrement");

	property p_rxDone;
		@(posedge core_clk) disable iff (!reset_n)
		rxDone |=> transferBuffer == $past(rxByte) && status.bufferFullFlag && state == IDLE;
	endproperty
	a_rxDone: assert property (p_rxDone) else $error("received byte not stored");

	property p_sdaHold;
		@(posedge core_clk) disable iff (!reset_n)
		state == TX_HIGH |=> $stable(sdaOe);
	endproperty
	a_sdaHold: assert property (p_sdaHold) else $error("data moved with clock");

endmodule : i2c_master_sequencer

/* testbench/i2c_slave_model.sv */
`timescale 1ns/100ps
// Behavioural slave: acknowledges, returns a byte, may stretch SCL
module i2c_slave_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic ackOn,
	input wire logic readOn,
	input wire logic stretchOn,
	input wire logic [7:0] readByte,
	output logic sdaPull,
	output logic sclPull
);
	logic [3:0] posCnt = 4'h0;
	logic [3:0] rdCnt = 4'h0;
	logic ackPull = 1'b0;
	// Read data changes only while SCL is low, so it is settled at each rise
	assign sdaPull = readOn ? (rdCnt < 4'h8 && !readByte[3'(4'h7 - rdCnt)]) : ackPull;
	initial sclPull = 1'b0;
	always @(posedge readOn) rdCnt = 4'h0;
	// Any start condition restarts the bit count
	always @(negedge sda) if (scl) posCnt = 4'h0;
	always @(posedge scl) posCnt = readOn ? 4'h0 : posCnt + 4'h1;
	// Acknowledge window spans the whole ninth clock
	always @(negedge scl) begin
		if (readOn) rdCnt = rdCnt + 4'h1;
		if (!readOn && posCnt == 4'h8) ackPull = ackOn;
		if (!readOn && posCnt == 4'h9) begin
			ackPull = 1'b0;
			posCnt = 4'h0;
		end
		if (stretchOn) begin
			sclPull = 1'b1;
			#100 sclPull = 1'b0;
		end
	end
endmodule : i2c_slave_model

/* testbench/test_i2c_master_sequencer.sv */
`timescale 1ns/100ps
`include "i2c_master_consts.svh"
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin errors++; $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module test_i2c_master_sequencer import i2c_master_pkg::*;;
	logic core_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, sclOe, sdaOe, sclPull, sdaPull, sdaHog = 1'b0, sclHog = 1'b0, sclLvl, sdaLvl;
	logic ackOn = 1'b0, readOn = 1'b0, stretchOn = 1'b0;
	logic [7:0] readByte = 8'h00, b;
	logic [15:0] lfsr = 16'h65b3;
	logic [8:0] monBits = 9'h000;
	int monCnt = 0, startCnt = 0, n = 0, errors = 0, checks = 0;
	port_status_t st;
	// Open-drain wires with pull-ups
	wire scl = !((sclOe && !sclLvl) || sclPull || sclHog);
	wire sda = !((sdaOe && !sdaLvl) || sdaPull || sdaHog);
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end
	i2c_master_sequencer uut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sclIn(scl), .sclOut(sclLvl), .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaLvl), .sdaOe(sdaOe));
	i2c_slave_model slave (.scl(scl), .sda(sda), .ackOn(ackOn), .readOn(readOn), .stretchOn(stretchOn),
		.readByte(readByte), .sdaPull(sdaPull), .sclPull(sclPull));
	// Line monitor, independent of the design's own detector
	always @(posedge scl) begin
		monBits = {monBits[7:0], sda};
		monCnt++;
	end
	always @(negedge sda) if (scl) startCnt++;
	function automatic logic [15:0] lfsrNext(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsrNext
	// Bits on the wire: byte MSB first, then the acknowledge level
	function automatic logic [8:0] expBits(input logic [7:0] v, input logic ack);
		return {v, !ack};
	endfunction : expBits
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		rd = prdata;
		err = pslverr;
		st = port_status_t'(prdata[5:0]);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Polls a bit; a bounded count keeps a stuck flag from hanging the run
	task automatic waitFor(input logic [11:0] a, input int i, input logic v);
		for (int k = 0; k < 400; k++) begin
			apb(1'b0, a, 32'h0);
			if (rd[i] === v) return;
		end
		errors++;
		$display("wrong value wait %h exp %h got %h", a, v, rd[i]);
	endtask : waitFor
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict
	initial begin
		repeat (30000) @(posedge core_clk);
		errors++;
		give_verdict();
	end
	initial begin
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
		apb(1'b0, `OFS_RATE_RELOAD, 32'h0);
		`CHK("reload", 32'h9, rd)
		apb(1'b0, `OFS_BUS_CONTROL, 32'h0);
		`CHK("control", 32'h0, rd)
		apb(1'b0, 12'h010, 32'h0);
		`CHK("slverr", 1'b1, err)
		`CHK("pin levels", 2'b00, {sclLvl, sdaLvl})
		$display("test reset done");
		// Start with SDA held low by another party, then with SCL pulled low during the first count
		for (int k = 0; k < 2; k++) begin
			sdaHog <= (k == 0);
			apb(1'b1, `OFS_BUS_CONTROL, 32'h1);
			sclHog <= (k == 1);
			waitFor(`OFS_BUS_CONTROL, 0, 1'b0);
			apb(1'b0, `OFS_PORT_STATUS, 32'h0);
			`CHK("collision", 1'b1, st.collisionIrqFlag)
			`CHK("released", 2'b00, {sclOe, sdaOe})
			sdaHog <= 1'b0;
			sclHog <= 1'b0;
			apb(1'b1, `OFS_PORT_STATUS, 32'h3f);
		end
		$display("test collision done");
		// Start with a buffer write and a control write both refused while it runs
		n = startCnt;
		apb(1'b1, `OFS_BUS_CONTROL, 32'h1);
		apb(1'b1, `OFS_TRANSFER_BUF, 32'h5a);
		apb(1'b1, `OFS_BUS_CONTROL, 32'h8);
		apb(1'b0, `OFS_BUS_CONTROL, 32'h0);
		`CHK("queued rx", 1'b0, rd[3])
		waitFor(`OFS_BUS_CONTROL, 0, 1'b0);
		apb(1'b0, `OFS_PORT_STATUS, 32'h0);
		`CHK("start status", 6'b010110, st)
		`CHK("start seen", n + 1, startCnt)
		`CHK("start lines", 2'b10, {scl, sda})
		apb(1'b1, `OFS_PORT_STATUS, 32'h3f);
		apb(1'b1, `OFS_RATE_RELOAD, 32'(lfsr[0]) + 32'h1);
		$display("test start done");
		// Acknowledged byte, then refused byte with clock stretching
		for (int k = 0; k < 2; k++) begin
			lfsr = lfsrNext(lfsr);
			b = lfsr[7:0];
			ackOn = (k == 0);
			stretchOn = (k == 1);
			monCnt = 0;
			apb(1'b1, `OFS_TRANSFER_BUF, {24'h0, b});
			apb(1'b0, `OFS_PORT_STATUS, 32'h0);
			`CHK("full", 1'b1, st.bufferFullFlag)
			apb(1'b1, `OFS_TRANSFER_BUF, {24'h0, ~b});
			waitFor(`OFS_PORT_STATUS, 4, 1'b1);
			`CHK("tx status", 6'b010010, st)
			`CHK("clocks", 9, monCnt)
			`CHK("tx bits", expBits(b, ackOn), monBits)
			`CHK("scl held", 1'b0, scl)
			apb(1'b0, `OFS_BUS_CONTROL, 32'h0);
			`CHK("ack status", !ackOn, rd[6])
			apb(1'b1, `OFS_PORT_STATUS, 32'h3f);
		end
		stretchOn = 1'b0;
		$display("test transmit done");
		// Three receptions, only the first read back, with requests refused meanwhile
		for (int k = 0; k < 3; k++) begin
			lfsr = lfsrNext(lfsr);
			readByte = lfsr[7:0];
			readOn = 1'b1;
			apb(1'b1, `OFS_BUS_CONTROL, 32'h8);
			apb(1'b1, `OFS_BUS_CONTROL, 32'ha);
			waitFor(`OFS_PORT_STATUS, 4, 1'b1);
			readOn = 1'b0;
			`CHK("rx full", 1'b1, st.bufferFullFlag)
			apb(1'b1, `OFS_PORT_STATUS, 32'h10);
			if (k == 0) begin
				apb(1'b0, `OFS_TRANSFER_BUF, 32'h0);
				`CHK("rx byte", readByte, rd[7:0])
			end
		end
		apb(1'b0, `OFS_BUS_CONTROL, 32'h0);
		`CHK("rx control", 4'h0, rd[3:0])
		apb(1'b0, `OFS_PORT_STATUS, 32'h0);
		`CHK("overflow", 1'b1, st.receiveOverflowFlag)
		apb(1'b0, `OFS_TRANSFER_BUF, 32'h0);
		apb(1'b0, `OFS_PORT_STATUS, 32'h0);
		`CHK("read clears", 1'b0, st.bufferFullFlag)
		$display("test receive done");
		// Acknowledge sequence sending a low
		monCnt = 0;
		apb(1'b1, `OFS_BUS_CONTROL, 32'h10);
		waitFor(`OFS_BUS_CONTROL, 4, 1'b0);
		`CHK("ack clocks", 1, monCnt)
		`CHK("ack level", 1'b0, monBits[0])
		$display("test acknowledge done");
		// Repeated start from idle with SCL low
		n = startCnt;
		apb(1'b1, `OFS_PORT_STATUS, 32'h3f);
		apb(1'b1, `OFS_BUS_CONTROL, 32'h2);
		waitFor(`OFS_BUS_CONTROL, 1, 1'b0);
		apb(1'b0, `OFS_PORT_STATUS, 32'h0);
		`CHK("restart seen", n + 1, startCnt)
		`CHK("restart flags", 2'b11, {st.startDetected, st.portIrqFlag})
		`CHK("restart lines", 2'b10, {scl, sda})
		// Restart with SDA held low by another party: aborted when the released SDA stays low
		sdaHog <= 1'b1;
		apb(1'b1, `OFS_BUS_CONTROL, 32'h2);
		waitFor(`OFS_BUS_CONTROL, 1, 1'b0);
		apb(1'b0, `OFS_PORT_STATUS, 32'h0);
		`CHK("restart collision", 1'b1, st.collisionIrqFlag)
		`CHK("restart released", 2'b00, {sclOe, sdaOe})
		sdaHog <= 1'b0;
		$display("test restart done");
		give_verdict();
	end
endmodule : test_i2c_master_sequencer
